// [hw/dtp_pkg.sv]
// package for the down-counting timer with pulse output
package dtp_pkg;

    // register word indices; byte address is four times the index
    localparam logic [2:0] IDX_DOWN_COUNT     = 3'h0;
    localparam logic [2:0] IDX_MODE_CONTROL   = 3'h1;
    localparam logic [2:0] IDX_CLOCK_CONTROL  = 3'h2;
    localparam logic [2:0] IDX_PULSE_DUTY     = 3'h3;
    localparam logic [2:0] IDX_PRESCALE_COUNT = 3'h4;
    localparam logic [2:0] IDX_IRQ_STATUS     = 3'h5;
    localparam logic [2:0] IDX_IRQ_MASK       = 3'h6;
    localparam int         ADDR_LSB           = 2;
    localparam int         ADDR_MSB           = 11;

    // timer_mode_control field positions
    localparam int MODE_ENABLE_POS   = 0;
    localparam int MODE_RELOAD_POS   = 1;
    localparam int MODE_ONESHOT_POS  = 2;
    localparam int MODE_POLARITY_POS = 6;
    localparam int MODE_PIN_OE_POS   = 7;

    // timer_clock_control field positions
    localparam int CLK_RATE_LSB  = 0;
    localparam int CLK_RATE_MSB  = 2;
    localparam int CLK_PS_DIS_POS = 3;
    localparam int CLK_EDGE_POS   = 4;
    localparam int CLK_SRC_POS    = 5;

    // status and mask layout
    localparam int IRQ_UNDERFLOW_POS = 0;

    // reset values and count limits
    localparam logic [7:0] RST_DOWN_COUNT    = 8'h00;
    localparam logic [7:0] RST_RELOAD        = 8'h00;
    localparam logic [7:0] RST_PULSE_DUTY    = 8'h00;
    localparam logic [7:0] RST_PRESCALE      = 8'hff;
    localparam logic [7:0] COUNT_TOP         = 8'hff;
    localparam logic [7:0] COUNT_BOTTOM      = 8'h00;

    typedef struct packed {
        logic pin_oe;
        logic polarity;
        logic one_shot;
        logic reload_sel;
        logic enable;
    } dtp_mode_type;

    typedef struct packed {
        logic       clock_source;
        logic       clock_edge;
        logic       prescale_disable_n;
        logic [2:0] rate;
    } dtp_clock_type;

    localparam dtp_mode_type  RST_MODE  = '{pin_oe: 1'b0, polarity: 1'b0, one_shot: 1'b0,
                                             reload_sel: 1'b0, enable: 1'b0};
    localparam dtp_clock_type RST_CLOCK = '{clock_source: 1'b1, clock_edge: 1'b1,
                                             prescale_disable_n: 1'b1, rate: 3'h7};

endpackage

// [hw/dtp_down_timer.sv]
// down-counting timer with prescaler, pulse output and apb register slave
//
// Decided for this implementation: the APB register port.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - reading the count register gives the live down-counter value
// - writing the count register sets both reload value and live counter
// - non-stop, reload-select clear: after 0x00 continue from 0xFF
// - non-stop, reload-select set: after 0x00 reload stored value
// - one-shot: count down to 0x00 then stop
// - polarity bit set makes pulse output active low, clear active high
// - output-enable bit routes pulse to pin two, else pin is plain i/o
// - after enable, pulse output stays inactive until duty match
// - count equal to duty makes pulse active until underflow
// - with reload-select set, reload value sets pulse period (else 256 counts); duty register sets duty
// - duty register is write-only, reads give zero
// - prescaler divides by two to the power rate plus one
// - external clock counts falling edges if edge bit set, else rising
// - source bit selects external pin when set, resets to one
// - prescale count register reads the live prescaler counter
// - each underflow sets a sticky flag until software clears it
module dtp_down_timer
    import dtp_pkg::*;
(
    // apb slave
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // timer clock sources
    input  wire logic        instr_tick,
    input  wire logic        external_clock_pin,
    // port pin two
    input  wire logic        gpio_out,
    input  wire logic        gpio_oe,
    output logic             port_pin_two_out,
    output logic             port_pin_two_oe,
    // interrupt
    output logic             irq
);

    // register state
    dtp_mode_type  mode_q;
    dtp_clock_type clk_q;
    logic [7:0]    count_q;
    logic [7:0]    reload_q;
    logic [7:0]    duty_q;
    logic [7:0]    presc_q;
    logic          status_q;
    logic          mask_q;
    logic          active_q;
    logic          en_prev_q;
    logic [31:0]   prdata_q;
    logic          pready_q;
    logic          pslverr_q;
    logic          pin_out_q;
    logic          pin_oe_q;
    logic          irq_q;
    logic [2:0]    ext_sync_q;
    logic          ext_level_q;

    // bus decode
    wire logic [9:0] word_idx   = paddr[ADDR_MSB:ADDR_LSB];
    wire logic       setup      = psel & ~penable & ~pready_q;
    wire logic       access_ok  = psel & penable & pready_q;
    wire logic       wr         = access_ok & pwrite;
    wire logic       mapped     = (word_idx <= 10'(IDX_IRQ_MASK));
    wire logic       hit_count  = wr & (word_idx == 10'(IDX_DOWN_COUNT));
    wire logic       hit_mode   = wr & (word_idx == 10'(IDX_MODE_CONTROL));
    wire logic       hit_clock  = wr & (word_idx == 10'(IDX_CLOCK_CONTROL));
    wire logic       hit_duty   = wr & (word_idx == 10'(IDX_PULSE_DUTY));
    wire logic       hit_status = wr & (word_idx == 10'(IDX_IRQ_STATUS));
    wire logic       hit_mask   = wr & (word_idx == 10'(IDX_IRQ_MASK));

    // read mux; write-only fields read as zero
    wire logic [7:0] mode_rd  = {5'h00, mode_q.one_shot, mode_q.reload_sel, mode_q.enable};
    wire logic [7:0] clock_rd = {2'h0, clk_q};
    wire logic [7:0] rd_byte  =
        (word_idx == 10'(IDX_DOWN_COUNT))     ? count_q :
        (word_idx == 10'(IDX_MODE_CONTROL))   ? mode_rd :
        (word_idx == 10'(IDX_CLOCK_CONTROL))  ? clock_rd :
        (word_idx == 10'(IDX_PRESCALE_COUNT)) ? presc_q :
        (word_idx == 10'(IDX_IRQ_STATUS))     ? {7'h00, status_q} :
        (word_idx == 10'(IDX_IRQ_MASK))       ? {7'h00, mask_q} :
                                                8'h00;

    // external clock: filtered level changes once stages two and three agree
    wire logic ext_settled = (ext_sync_q[1] == ext_sync_q[2]);
    wire logic ext_change  = ext_settled & (ext_sync_q[2] != ext_level_q);
    wire logic ext_rise    = ext_change & ext_sync_q[2];
    wire logic ext_fall    = ext_change & ~ext_sync_q[2];
    wire logic ext_event   = clk_q.clock_edge ? ext_fall : ext_rise;
    wire logic src_event   = clk_q.clock_source ? ext_event : instr_tick;

    // prescaler: terminal when the low rate+1 bits of the count are zero
    wire logic [7:0] rate_mask  = 8'((9'h002 << clk_q.rate) - 9'h001);
    wire logic       presc_on   = ~clk_q.prescale_disable_n;
    wire logic       presc_term = src_event & ((presc_q & rate_mask) == 8'h00);
    wire logic       step_event = presc_on ? presc_term : src_event;

    // counter
    wire logic       running    = mode_q.enable;
    wire logic       step       = running & step_event;
    wire logic       underflow  = step & (count_q == COUNT_BOTTOM);
    wire logic [7:0] wrap_value = mode_q.reload_sel ? reload_q : COUNT_TOP;
    wire logic       stop_now   = underflow & mode_q.one_shot;

    logic [7:0] count_d;
    always_comb
    begin
        if (hit_count)
            count_d = pwdata[7:0];
        else if (stop_now)
            count_d = COUNT_BOTTOM;
        else if (underflow)
            count_d = wrap_value;
        else if (step)
            count_d = count_q - 8'h01;
        else
            count_d = count_q;
    end

    // pulse state: cleared on start and at underflow, set on duty match
    wire logic start     = running & ~en_prev_q;
    wire logic duty_hit  = running & (count_q == duty_q);
    logic active_d;
    always_comb
    begin
        if (start | underflow)
            active_d = 1'b0;
        else if (duty_hit)
            active_d = 1'b1;
        else
            active_d = active_q;
    end
    wire logic pulse_level = active_d ^ mode_q.polarity;
    wire logic pin_out_d   = mode_q.pin_oe ? pulse_level : gpio_out;
    wire logic pin_oe_d    = mode_q.pin_oe ? 1'b1 : gpio_oe;

    // mode register; one-shot stop clears enable unless software writes it
    dtp_mode_type mode_d;
    always_comb
    begin
        mode_d = mode_q;
        if (stop_now)
            mode_d.enable = 1'b0;
        if (hit_mode)
            mode_d = '{pin_oe:     pwdata[MODE_PIN_OE_POS],
                       polarity:   pwdata[MODE_POLARITY_POS],
                       one_shot:   pwdata[MODE_ONESHOT_POS],
                       reload_sel: pwdata[MODE_RELOAD_POS],
                       enable:     pwdata[MODE_ENABLE_POS]};
    end

    // flag: set wins over a write-one clear in the same cycle
    wire logic status_d = underflow |
                          (status_q & ~(hit_status & pwdata[IRQ_UNDERFLOW_POS]));

    // prescaler counter only moves while enabled; holds otherwise
    wire logic [7:0] presc_d = (presc_on & src_event) ? presc_q - 8'h01 : presc_q;

    // plain register writes plus the enable history; the timer logic never updates the written ones itself
    wire logic [7:0] reload_d  = hit_count ? pwdata[7:0] : reload_q;
    wire logic [7:0] duty_d    = hit_duty ? pwdata[7:0] : duty_q;
    wire logic       mask_d    = hit_mask ? pwdata[IRQ_UNDERFLOW_POS] : mask_q;
    wire logic       en_prev_d = mode_q.enable;
    dtp_clock_type   clk_d;
    // no guard against a rate change while the prescaler runs; software must avoid it
    assign clk_d = hit_clock ? dtp_clock_type'(pwdata[CLK_SRC_POS:CLK_RATE_LSB]) : clk_q;

    // bus answer registered one cycle after setup, so every access is two cycles
    wire logic        pready_d  = setup;
    wire logic        pslverr_d = setup & ~mapped;
    wire logic [31:0] prdata_d  = (setup & ~pwrite) ? {24'h000000, rd_byte} : 32'h0000_0000;

    // interrupt level and external clock synchroniser
    wire logic       irq_d       = status_d & mask_q;
    wire logic [2:0] ext_sync_d  = {ext_sync_q[1:0], external_clock_pin};
    wire logic       ext_level_d = ext_settled ? ext_sync_q[2] : ext_level_q;

    // timer registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mode_q <= RST_MODE;
        end
        else
        begin
            mode_q <= mode_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            clk_q <= RST_CLOCK;
        end
        else
        begin
            clk_q <= clk_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            count_q <= RST_DOWN_COUNT;
        end
        else
        begin
            count_q <= count_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            reload_q <= RST_RELOAD;
        end
        else
        begin
            reload_q <= reload_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            duty_q <= RST_PULSE_DUTY;
        end
        else
        begin
            duty_q <= duty_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            presc_q <= RST_PRESCALE;
        end
        else
        begin
            presc_q <= presc_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            status_q <= 1'b0;
        end
        else
        begin
            status_q <= status_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mask_q <= 1'b0;
        end
        else
        begin
            mask_q <= mask_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            active_q  <= 1'b0;
            en_prev_q <= 1'b0;
        end
        else
        begin
            active_q  <= active_d;
            en_prev_q <= en_prev_d;
        end
    end

    // bus answer registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_q <= 32'h0000_0000;
        end
        else
        begin
            prdata_q <= prdata_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end
        else
        begin
            pready_q  <= pready_d;
            pslverr_q <= pslverr_d;
        end
    end

    // pin, interrupt and synchroniser registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin_out_q <= 1'b0;
            pin_oe_q  <= 1'b0;
        end
        else
        begin
            pin_out_q <= pin_out_d;
            pin_oe_q  <= pin_oe_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_q <= 1'b0;
        end
        else
        begin
            irq_q <= irq_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ext_sync_q  <= 3'h0;
            ext_level_q <= 1'b0;
        end
        else
        begin
            ext_sync_q  <= ext_sync_d;
            ext_level_q <= ext_level_d;
        end
    end

    assign prdata           = prdata_q;
    assign pready           = pready_q;
    assign pslverr          = pslverr_q;
    assign port_pin_two_out = pin_out_q;
    assign port_pin_two_oe  = pin_oe_q;
    assign irq              = irq_q;

endmodule // dtp_down_timer

`default_nettype wire

// [test/dtp_down_timer_checker.sv]
// concurrent checks on the down timer ports
`timescale 1ns/1ps
`default_nettype none
module dtp_down_timer_checker (
    // apb
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // pin and interrupt
    input wire logic        gpio_out,
    input wire logic        gpio_oe,
    input wire logic        port_pin_two_out,
    input wire logic        port_pin_two_oe,
    input wire logic        irq
);
    logic       pin_en_q;
    logic       mask_q;
    wire  [9:0] idx = paddr[11:2];
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // shadows of write-only routing and the mask, so pin and irq can be judged
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            {pin_en_q, mask_q} <= 2'h0;
        else if (psel && penable && pready && pwrite && idx == 10'h1)
            pin_en_q <= pwdata[7];
        else if (psel && penable && pready && pwrite && idx == 10'h6)
            mask_q <= pwdata[0];
    end
    a_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("ready held too long");
    a_error_unmapped: assert property (pready |-> pslverr == (idx > 10'h6))
        else $error("wrong slave error");
    a_idle_bus_quiet: assert property (!pready |-> prdata == 32'h0 && !pslverr)
        else $error("read data outside access");
    a_duty_reads_zero: assert property (pready && !pwrite && idx == 10'h3 |-> prdata == 32'h0)
        else $error("duty readable");
    // the pin leaves reset at zero whatever gpio held, so the first edge out of reset is not judged
    a_pin_follows_gpio: assert property (!pin_en_q && !$past(pin_en_q) && $past(presetn) |->
        port_pin_two_out == $past(gpio_out) && port_pin_two_oe == $past(gpio_oe))
        else $error("pin not plain io");
    a_pin_driven_on: assert property (pin_en_q && $past(pin_en_q) |-> port_pin_two_oe)
        else $error("pin not driven");
    a_irq_masked_off: assert property (!mask_q && !$past(mask_q) |-> !irq)
        else $error("masked irq raised");
    c_irq_rise: cover property ($rose(irq));
    c_slave_error: cover property (pready && pslverr);
    c_pulse_routed: cover property (pin_en_q && port_pin_two_out);
endmodule // dtp_down_timer_checker
`default_nettype wire

// [test/test_dtp_down_timer.sv]
// self-checking bench for the down timer with pulse output
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_count++; $display("Error %0t: %h vs %h", $time, a, b); end end
module test_dtp_down_timer
    import dtp_pkg::*;
;
    localparam logic [7:0] RST_V [5] = '{8'h00, 8'h00, 8'h3f, 8'h00, 8'hff};
    localparam logic [7:0] MODES [4] = '{8'h01, 8'h03, 8'h05, 8'h07};
    localparam logic [2:0] RATES [4] = '{3'h0, 3'h1, 3'h2, 3'h7};
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
    logic        instr_tick, ext_pin, gpio_out, gpio_oe, pin_out, pin_oe, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic [7:0]  v;
    logic [8:0]  e;
    int          n, cyc, err_count, n_checks;
    int          seed = 32'h9b974670;
    dtp_down_timer u_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .instr_tick(instr_tick),
        .external_clock_pin(ext_pin), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
        .port_pin_two_out(pin_out), .port_pin_two_oe(pin_oe), .irq(irq));
    task automatic apb(input logic w, input logic [9:0] i, input logic [7:0] d);
        {psel, penable, pwrite} <= {1'b1, 1'b0, w};
        paddr  <= {i, 2'h0};
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        {rdat, rerr} = {prdata, pslverr};
        {psel, penable} <= 2'h0;
        @(posedge pclk);
    endtask
    task automatic tick(input int k);
        repeat (k)
        begin
            instr_tick <= 1'b1;
            @(posedge pclk);
            instr_tick <= 1'b0;
            repeat (3) @(posedge pclk);
        end
    endtask
    // count and underflow flag after k source events
    function automatic logic [8:0] model(input logic [7:0] m, input logic [7:0] v0, input int k);
        logic [7:0] c;
        logic       uf;
        {uf, c} = {1'b0, v0};
        for (int s = 0; s < k; s++)
            if (m[0] && c == 8'h00)
            begin
                uf   = 1'b1;
                m[0] = !m[2];
                c    = m[2] ? c : (m[1] ? v0 : 8'hff);
            end
            else if (m[0])
                c = c - 8'h01;
        return {uf, c};
    endfunction
    task automatic finish_test;
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial
    begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    // random pin traffic keeps the plain io path busy; cycle ceiling cuts hangs
    always @(posedge pclk)
    begin
        cyc++;
        {gpio_out, gpio_oe} <= 2'($random(seed));
        if (cyc > 30000)
        begin
            err_count++;
            $display("Error %0t: cycle limit reached", $time);
            finish_test();
        end
    end
    initial
    begin
        {presetn, psel, penable, pwrite, instr_tick, ext_pin} = 6'h00;
        {paddr, pwdata} = 44'h0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < 5; i++)
        begin
            apb(0, 10'(i), 8'h00);
            `CHK(rdat[7:0], RST_V[i])
        end
        apb(1, 10'h7, 8'h5a);
        `CHK(rerr, 1'b1)
        apb(1, 2, 8'h08);
        for (int p = 0; p < 2; p++)
        begin
            apb(1, 3, 8'h02);
            apb(0, 3, 8'h00);
            `CHK(rdat, 32'h0)
            apb(1, 0, 8'h05);
            apb(1, 1, {1'b1, p[0], 6'h03});
            repeat (2) @(posedge pclk);
            `CHK(pin_oe, 1'b1)
            `CHK(pin_out, p[0])
            v = 8'h05;
            repeat (9)
            begin
                tick(1);
                v = (v == 8'h00) ? 8'h05 : v - 8'h01;
                `CHK(pin_out, (v <= 8'h02) ^ p[0])
            end
            apb(1, 1, 8'h00);
        end
        for (int i = 0; i < 8; i++)
        begin
            v = 8'($random(seed)) & 8'h0f;
            n = $random(seed) & 31;
            apb(1, 6, {7'h0, i[0]});
            apb(1, 5, 8'h01);
            `CHK(irq, 1'b0)
            apb(1, 0, v);
            apb(1, 1, MODES[i % 4]);
            tick(n);
            apb(1, 1, 8'h00);
            tick(2);
            e = model(MODES[i % 4], v, n);
            apb(0, 0, 8'h00);
            `CHK(rdat[7:0], e[7:0])
            apb(0, 5, 8'h00);
            `CHK(rdat[0], e[8])
            `CHK(irq, e[8] & i[0])
        end
        for (int x = 0; x < 2; x++)
        begin
            apb(1, 2, {2'h0, 1'b1, x[0], 4'h8});
            apb(1, 0, 8'h0a);
            apb(1, 1, 8'h01);
            ext_pin <= 1'b1;
            repeat (8) @(posedge pclk);
            apb(0, 0, 8'h00);
            `CHK(rdat[7:0], x ? 8'h0a : 8'h09)
            ext_pin <= 1'b0;
            repeat (8) @(posedge pclk);
            apb(0, 0, 8'h00);
            `CHK(rdat[7:0], 8'h09)
            apb(1, 1, 8'h00);
        end
        foreach (RATES[j])
        begin
            apb(1, 2, {5'h01, RATES[j]});
            apb(1, 2, {5'h00, RATES[j]});
            apb(0, 4, 8'h00);
            v = rdat[7:0];
            apb(1, 0, 8'h0a);
            apb(1, 1, 8'h01);
            tick(2 << RATES[j]);
            apb(1, 1, 8'h00);
            apb(0, 0, 8'h00);
            `CHK(rdat[7:0], 8'h09)
            apb(0, 4, 8'h00);
            `CHK(rdat[7:0], 8'(v - (2 << RATES[j])))
        end
        finish_test();
    end
endmodule // test_dtp_down_timer
bind dtp_down_timer dtp_down_timer_checker u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .gpio_out(gpio_out),
    .gpio_oe(gpio_oe), .port_pin_two_out(port_pin_two_out), .port_pin_two_oe(port_pin_two_oe), .irq(irq));
`default_nettype wire
